// ---- common/mad_pkg.sv ----
package mad_pkg;

  // ****************************************************************
  // Memory map and timing constants
  // ****************************************************************
  localparam logic [15:0] SRAM_TOP_ADDR  = 16'h03FF;
  localparam logic [15:0] ROM_TOP_ADDR   = 16'h7FFF;
  localparam int          SRAM_DEPTH     = 1024;
  localparam int          SRAM_AW        = 10;
  localparam logic [7:0]  OP_PTR_DEC     = 8'hA5;
  localparam int          SRAM_EN_BIT    = 0;
  localparam logic        SRAM_EN_RESET  = 1'b0;
  localparam logic [1:0]  MC_LAST_CLK    = 2'h3;   // Four clocks per machine cycle
  localparam logic [2:0]  STRETCH_MAX    = 3'h7;   // Strobe machine cycles minus one
  localparam logic [7:0]  PORT_IDLE      = 8'hFF;
  localparam logic [15:0] PTR_RESET      = 16'h0000;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    KIND_FETCH = 2'b00,
    KIND_CODE  = 2'b01,
    KIND_XRD   = 2'b10,
    KIND_XWR   = 2'b11
  } mad_kind_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ROM  = 3'b001,
    ST_SRAM = 3'b010,
    ST_ADDR = 3'b011,
    ST_STRB = 3'b100
  } mad_state_type;

  typedef struct packed {
    logic         valid;
    mad_kind_type kind;
    logic [15:0]  addr;
    logic [7:0]   wdata;
  } mad_req_type;

  typedef struct packed {
    logic [7:0] p0_out;
    logic [7:0] p0_oe;
    logic [7:0] p2_out;
    logic [7:0] p2_oe;
    logic       ale;
    logic       psen_n;
    logic       rd_n;
    logic       wr_n;
  } mad_bus_type;

endpackage : mad_pkg

// ---- src/mad_sram.sv ----
module mad_sram
  import mad_pkg::*;
(
  // Clock
  input  wire logic               sys_clk,
  // Access
  input  wire logic               we,
  input  wire logic [SRAM_AW-1:0] addr,
  input  wire logic [7:0]         wdata,
  output logic      [7:0]         rdata
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [7:0] mem [SRAM_DEPTH];

  // Data contents carry no reset; read data is registered like a sync RAM
  always_ff @(posedge sys_clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end

endmodule : mad_sram

// ---- src/mad_top.sv ----
module mad_top
  import mad_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // Core access port
  input  wire mad_req_type req,
  input  wire logic [2:0]  stretch_cfg,
  output logic             ready_reg,
  output logic             done_reg,
  output logic [7:0]       rdata_reg,
  // Power management register write and view
  input  wire logic        power_management_register_wr,
  input  wire logic [7:0]  power_management_register_wdata,
  output logic             onchip_sram_enable_bit_reg,
  // Data pointers
  input  wire logic        ptr_active_sel,
  input  wire logic        ptr_wr_lo,
  input  wire logic        ptr_wr_hi,
  input  wire logic        ptr_wr_idx,
  input  wire logic [7:0]  ptr_wdata,
  input  wire logic        opcode_valid,
  input  wire logic [7:0]  opcode,
  output logic [15:0]      ptr0_reg,
  output logic [15:0]      ptr1_reg,
  // ROM port
  input  wire logic [7:0]  rom_rdata,
  output logic             rom_en_reg,
  output logic [15:0]      rom_addr_reg,
  // External bus pins and general purpose values
  input  wire logic [7:0]  p0_in,
  input  wire logic [7:0]  gpio_p0,
  input  wire logic [7:0]  gpio_p2,
  output mad_bus_type      bus_reg,
  // Wait request pin
  input  wire logic        wait_enable,
  input  wire logic        wait_request_pin_in,
  input  wire logic        gpio_p4_0,
  output logic             wait_request_pin_out_reg,
  output logic             wait_request_pin_oe_reg
);

  // ****************************************************************
  // State
  // ****************************************************************
  mad_state_type state_reg, state_next;
  mad_kind_type  kind_reg, kind_next;
  logic [15:0]   addr_reg, addr_next, ptr0_next, ptr1_next;
  logic [7:0]    wdata_reg, wdata_next, rdata_next;
  logic [2:0]    stretch_reg, stretch_next, mc_cnt_reg, mc_cnt_next;
  logic [1:0]    clk_cnt_reg, clk_cnt_next;
  logic          ready_next, done_next, rom_en_next, sram_en_next, wait_level_reg, wait_level_next;
  logic [15:0]   rom_addr_next;
  mad_bus_type   bus_next;
  logic [7:0]    p0_s1_reg, p0_s2_reg, p0_s3_reg;
  logic [2:0]    wait_sync_reg;
  logic          sram_we;
  logic [7:0]    sram_rdata;

  // Code fetches stop at the ROM top; data never falls into the SRAM range for code
  function automatic mad_state_type route(mad_kind_type k, logic [15:0] a, logic en);
    if (k == KIND_FETCH || k == KIND_CODE) begin
      route = (a <= ROM_TOP_ADDR) ? ST_ROM : ST_ADDR;
    end else if (en && a <= SRAM_TOP_ADDR) begin
      route = ST_SRAM;
    end else begin
      route = ST_ADDR;
    end
  endfunction : route

  // Pin view of each state; outside the bus phases port 2 floats and port 0 drives only its low general bits
  function automatic mad_bus_type pins(mad_state_type s, mad_kind_type k, logic [15:0] a,
                                       logic [7:0] d, logic [7:0] g0, logic [7:0] g2);
    pins = '{p0_out: g0, p0_oe: ~g0, p2_out: g2, p2_oe: 8'h00, ale: 1'b0,
             psen_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1};
    if (s == ST_ADDR) begin
      pins.p0_out = a[7:0];
      pins.p0_oe  = PORT_IDLE;
      pins.p2_out = a[15:8];
      pins.p2_oe  = PORT_IDLE;
      pins.ale    = 1'b1;
    end else if (s == ST_STRB) begin
      pins.p0_out = d;
      pins.p0_oe  = (k == KIND_XWR) ? PORT_IDLE : 8'h00;
      pins.p2_out = a[15:8];
      pins.p2_oe  = PORT_IDLE;
      pins.psen_n = ~(k == KIND_FETCH || k == KIND_CODE);
      pins.rd_n   = ~(k == KIND_XRD);
      pins.wr_n   = ~(k == KIND_XWR);
    end
  endfunction : pins

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  // Port 0 and the wait pin come from outside the clock domain
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      p0_s1_reg      <= PORT_IDLE;
      p0_s2_reg      <= PORT_IDLE;
      p0_s3_reg      <= PORT_IDLE;
      wait_sync_reg  <= 3'h0;
      wait_level_reg <= 1'b0;
    end else begin
      p0_s1_reg      <= p0_in;
      p0_s2_reg      <= p0_s1_reg;
      p0_s3_reg      <= p0_s2_reg;
      wait_sync_reg  <= {wait_sync_reg[1:0], wait_request_pin_in};
      wait_level_reg <= wait_level_next;
    end
  end

  // A wait change counts only once stages two and three agree
  assign wait_level_next = (wait_sync_reg[1] == wait_sync_reg[2]) ? wait_sync_reg[2] : wait_level_reg;

  // ****************************************************************
  // On-chip data SRAM
  // ****************************************************************
  assign sram_we = ready_reg && req.valid && req.kind == KIND_XWR && route(req.kind, req.addr,
                   onchip_sram_enable_bit_reg) == ST_SRAM;

  mad_sram u_sram (
    .sys_clk (sys_clk),
    .we      (sram_we),
    .addr    (req.addr[SRAM_AW-1:0]),
    .wdata   (req.wdata),
    .rdata   (sram_rdata)
  );

  // ****************************************************************
  // Access sequencer
  // ****************************************************************
  // Next values of the access state machine and the bus pins
  always_comb begin
    state_next    = state_reg;
    kind_next     = kind_reg;
    addr_next     = addr_reg;
    wdata_next    = wdata_reg;
    stretch_next  = stretch_reg;
    clk_cnt_next  = clk_cnt_reg + 2'h1;
    mc_cnt_next   = mc_cnt_reg;
    done_next     = 1'b0;
    rdata_next    = rdata_reg;
    rom_en_next   = 1'b0;
    rom_addr_next = rom_addr_reg;
    case (state_reg)
      ST_IDLE: begin
        if (req.valid) begin
          kind_next    = req.kind;
          addr_next    = req.addr;
          wdata_next   = req.wdata;
          stretch_next = stretch_cfg;
          clk_cnt_next = 2'h0;
          mc_cnt_next  = 3'h0;
          state_next   = route(req.kind, req.addr, onchip_sram_enable_bit_reg);
          if (state_next == ST_ROM) begin
            rom_en_next   = 1'b1;
            rom_addr_next = req.addr;
          end
        end
      end
      ST_ROM: begin
        rdata_next = rom_rdata;
        done_next  = 1'b1;
        state_next = ST_IDLE;
      end
      ST_SRAM: begin
        if (kind_reg == KIND_XRD) begin
          rdata_next = sram_rdata;
        end
        done_next  = 1'b1;
        state_next = ST_IDLE;
      end
      ST_ADDR: begin
        // Address phase is one machine cycle
        if (clk_cnt_reg == MC_LAST_CLK) begin
          state_next = ST_STRB;
        end
      end
      ST_STRB: begin
        // Strobe holds for stretch plus one machine cycles, longer while wait is held
        if (clk_cnt_reg == MC_LAST_CLK) begin
          if (mc_cnt_reg != stretch_reg) begin
            mc_cnt_next = mc_cnt_reg + 3'h1;
          end else if (!(wait_enable && wait_level_reg)) begin
            if (kind_reg != KIND_XWR) begin
              rdata_next = p0_s3_reg;
            end
            done_next  = 1'b1;
            state_next = ST_IDLE;
          end
        end
      end
      default: state_next = ST_IDLE;
    endcase
    ready_next = (state_next == ST_IDLE);
    bus_next   = pins(state_next, kind_next, addr_next, wdata_next, gpio_p0, gpio_p2);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg    <= ST_IDLE;
      kind_reg     <= KIND_FETCH;
      addr_reg     <= PTR_RESET;
      wdata_reg    <= 8'h00;
      stretch_reg  <= 3'h0;
      clk_cnt_reg  <= 2'h0;
      mc_cnt_reg   <= 3'h0;
      ready_reg    <= 1'b1;
      done_reg     <= 1'b0;
      rdata_reg    <= 8'h00;
      rom_en_reg   <= 1'b0;
      rom_addr_reg <= PTR_RESET;
      bus_reg      <= '{p0_out: PORT_IDLE, p0_oe: 8'h00, p2_out: PORT_IDLE, p2_oe: 8'h00,
                        ale: 1'b0, psen_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1};
    end else begin
      state_reg    <= state_next;
      kind_reg     <= kind_next;
      addr_reg     <= addr_next;
      wdata_reg    <= wdata_next;
      stretch_reg  <= stretch_next;
      clk_cnt_reg  <= clk_cnt_next;
      mc_cnt_reg   <= mc_cnt_next;
      ready_reg    <= ready_next;
      done_reg     <= done_next;
      rdata_reg    <= rdata_next;
      rom_en_reg   <= rom_en_next;
      rom_addr_reg <= rom_addr_next;
      bus_reg      <= bus_next;
    end
  end

  // ****************************************************************
  // Enable bit, data pointers and wait pin
  // ****************************************************************
  // Pointer writes take priority over a decrement in the same cycle
  always_comb begin
    sram_en_next = onchip_sram_enable_bit_reg;
    if (power_management_register_wr) begin
      sram_en_next = power_management_register_wdata[SRAM_EN_BIT];
    end
    ptr0_next = ptr0_reg;
    ptr1_next = ptr1_reg;
    if (opcode_valid && opcode == OP_PTR_DEC) begin
      if (ptr_active_sel) begin
        ptr1_next = ptr1_reg - 16'h0001;
      end else begin
        ptr0_next = ptr0_reg - 16'h0001;
      end
    end
    if (ptr_wr_lo && !ptr_wr_idx) ptr0_next[7:0]  = ptr_wdata;
    if (ptr_wr_hi && !ptr_wr_idx) ptr0_next[15:8] = ptr_wdata;
    if (ptr_wr_lo && ptr_wr_idx)  ptr1_next[7:0]  = ptr_wdata;
    if (ptr_wr_hi && ptr_wr_idx)  ptr1_next[15:8] = ptr_wdata;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      onchip_sram_enable_bit_reg <= SRAM_EN_RESET;
      ptr0_reg                   <= PTR_RESET;
      ptr1_reg                   <= PTR_RESET;
      wait_request_pin_out_reg   <= 1'b1;
      wait_request_pin_oe_reg    <= 1'b0;
    end else begin
      onchip_sram_enable_bit_reg <= sram_en_next;
      ptr0_reg                   <= ptr0_next;
      ptr1_reg                   <= ptr1_next;
      wait_request_pin_out_reg   <= gpio_p4_0;
      wait_request_pin_oe_reg    <= !wait_enable && !gpio_p4_0;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  logic [5:0] strb_len_reg;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) strb_len_reg <= 6'h00;
    else        strb_len_reg <= (state_reg == ST_STRB) ? strb_len_reg + 6'h01 : 6'h00;
  end

  sram_route_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ready_reg && req.valid && req.kind[1] && onchip_sram_enable_bit_reg && req.addr <= SRAM_TOP_ADDR
    |=> state_reg == ST_SRAM ##1 done_reg && bus_reg.rd_n && bus_reg.wr_n && !bus_reg.ale)
    else $error("sram access reached the external bus");
  ext_route_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ready_reg && req.valid && req.kind[1] && (!onchip_sram_enable_bit_reg || req.addr > SRAM_TOP_ADDR)
    |=> bus_reg.ale && bus_reg.p2_out == $past(req.addr[15:8]))
    else $error("external move did not start a bus cycle");
  mc_length_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(bus_reg.ale) |-> bus_reg.ale [*4] ##1 !bus_reg.ale)
    else $error("address phase is not four clocks");
  strobe_len_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $fell(state_reg == ST_STRB) && !wait_enable |-> $past(strb_len_reg) == 6'(({3'h0, stretch_reg} + 6'h01) * 6'h04) - 6'h01)
    else $error("strobe length differs from stretch setting");
  ptr_dec_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    opcode_valid && opcode == OP_PTR_DEC && !ptr_active_sel && !ptr_wr_lo && !ptr_wr_hi
    |=> ptr0_reg == $past(ptr0_reg) - 16'h0001)
    else $error("pointer decrement wrong");
  p0_drive_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    bus_reg.ale |-> bus_reg.p0_oe == PORT_IDLE && bus_reg.p2_oe == PORT_IDLE)
    else $error("ports not driven during address phase");
  rom_route_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ready_reg && req.valid && !req.kind[1] && req.addr <= ROM_TOP_ADDR |=> rom_en_reg && state_reg == ST_ROM)
    else $error("code access not served by rom");
  wait_pin_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wait_enable |=> !wait_request_pin_oe_reg)
    else $error("wait pin driven while wait enabled");
  strobe_kind_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !bus_reg.rd_n || !bus_reg.wr_n |-> state_reg == ST_STRB && kind_reg[1])
    else $error("data strobe outside external data cycle");

endmodule : mad_top

// ---- tb/mad_ext_mem.sv ----
module mad_ext_mem
  import mad_pkg::*;
(
  // Clock and answer speed
  input  wire logic        sys_clk,
  input  wire logic        slow,
  // Bus as seen at the pins
  input  wire mad_bus_type bus,
  output logic [7:0]       p0_drv,
  output logic             wait_req,
  // Strobe counts
  output int               rd_cnt,
  output int               wr_cnt,
  output int               psen_cnt
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0]  mem [0:65535];
  logic [15:0] lat_addr;
  logic [7:0]  wbyte;
  logic        rd_d;
  logic        wr_d;
  logic        ps_d;
  int          hold;

  // Pattern fill, so unwritten reads are still predictable
  initial begin
    for (int i = 0; i < 65536; i++)
      mem[i] = i[7:0] ^ i[15:8] ^ 8'hC3;
    {rd_d, wr_d, ps_d} = 3'h7;
    {rd_cnt, wr_cnt, psen_cnt, hold} = '0;
    p0_drv = 8'h00;
    wait_req = 1'b0;
  end

  // Sampled mid-cycle, away from the edge where the bus changes
  always @(negedge sys_clk) begin
    rd_d <= bus.rd_n;
    wr_d <= bus.wr_n;
    ps_d <= bus.psen_n;
    if (bus.ale)
      lat_addr <= {bus.p2_out, bus.p0_out};
    if (!bus.wr_n)
      wbyte <= bus.p0_out;
    if (!wr_d && bus.wr_n)
      mem[lat_addr] <= wbyte;
    rd_cnt <= rd_cnt + int'(rd_d && !bus.rd_n);
    wr_cnt <= wr_cnt + int'(wr_d && !bus.wr_n);
    psen_cnt <= psen_cnt + int'(ps_d && !bus.psen_n);
    // A slow device holds wait and keeps data back for eight clocks
    if (!bus.rd_n || !bus.psen_n) begin
      hold <= hold + 1;
      wait_req <= slow && hold < 8;
      p0_drv <= (slow && hold < 8) ? ~p0_drv : mem[lat_addr];
    end else begin
      hold <= 0;
      wait_req <= 1'b0;
      p0_drv <= ~p0_drv;
    end
  end
endmodule : mad_ext_mem

// ---- tb/mad_top_tb.sv ----
module mad_top_tb
  import mad_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        sys_clk, rst_n, ready_reg, done_reg, pm_wr, onchip_sram_enable_bit_reg;
  logic        ptr_active_sel, ptr_wr_lo, ptr_wr_hi, ptr_wr_idx, opcode_valid, rom_en_reg;
  logic        wait_en, wait_pin, gpio_p4_0, wpo, wpoe, wait_req, slow, en_m;
  logic [2:0]  stretch_cfg;
  logic [7:0]  rdata_reg, pm_wd, ptr_wdata, opcode, rom_rdata, p0_in, gpio_p0, gpio_p2, p0_drv;
  logic [15:0] ptr0_reg, ptr1_reg, rom_addr_reg, p0m, p1m;
  mad_req_type req;
  mad_bus_type bus_reg;
  int          rd_cnt, wr_cnt, psen_cnt, error_cnt, cmp_count;
  logic [7:0]  ext_ref [logic [15:0]];
  logic [7:0]  sram_ref [logic [15:0]];

  // Wired pins: port 0 and the wait pin resolved from both parties
  assign p0_in = (bus_reg.p0_oe & bus_reg.p0_out) | (~bus_reg.p0_oe & p0_drv);
  assign wait_pin = wpoe ? wpo : wait_req;

  mad_top mad_top_inst (.sys_clk, .rst_n, .req, .stretch_cfg, .ready_reg, .done_reg,
    .rdata_reg, .power_management_register_wr(pm_wr), .power_management_register_wdata(pm_wd),
    .onchip_sram_enable_bit_reg, .ptr_active_sel, .ptr_wr_lo, .ptr_wr_hi, .ptr_wr_idx, .ptr_wdata,
    .opcode_valid, .opcode, .ptr0_reg, .ptr1_reg, .rom_rdata, .rom_en_reg, .rom_addr_reg, .p0_in,
    .gpio_p0, .gpio_p2, .bus_reg, .wait_enable(wait_en), .wait_request_pin_in(wait_pin), .gpio_p4_0,
    .wait_request_pin_out_reg(wpo), .wait_request_pin_oe_reg(wpoe));

  mad_ext_mem mad_ext_mem_inst (.sys_clk, .slow, .bus(bus_reg), .p0_drv, .wait_req, .rd_cnt, .wr_cnt,
    .psen_cnt);

  function automatic logic [7:0] rom_byte(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction : rom_byte

  // 100 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ROM answers within the cycle in which its enable stands, as the sequencer samples it at the next edge
  always @(negedge sys_clk)
    if (rom_en_reg)
      rom_rdata <= rom_byte(rom_addr_reg);

  // Port roles while the bus is busy
  always @(negedge sys_clk) begin
    if (rst_n && bus_reg.ale)
      chk({bus_reg.p0_oe, bus_reg.p2_oe}, 16'hFFFF);
    if (rst_n && !bus_reg.rd_n)
      chk(bus_reg.p0_oe, 16'h0000);
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_n(input int got, input int exp);
    cmp_count++;
    if (got != exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_n

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : summarize

  // One access: held until taken, then waits for done under a bound
  task automatic acc(input mad_kind_type k, input logic [15:0] a, input logic [7:0] d,
                     input logic [2:0] s, output logic [7:0] rd, output int cyc);
    int n;
    n = 0;
    req <= '{1'b1, k, a, d};
    stretch_cfg <= s;
    do begin
      @(negedge sys_clk);
      n++;
    end while (ready_reg !== 1'b1 && n < 50);
    @(posedge sys_clk);
    req.valid <= 1'b0;
    cyc = 0;
    do begin
      @(negedge sys_clk);
      cyc++;
    end while (done_reg !== 1'b1 && cyc < 200);
    chk_n(int'(done_reg === 1'b1), 1);
    rd = rdata_reg;
    @(posedge sys_clk);
  endtask : acc

  // Access with routing, timing, strobe and data all predicted
  task automatic xacc(input mad_kind_type k, input logic [15:0] a, input logic [7:0] d, input logic [2:0] s);
    logic [7:0] rd, e;
    int cyc, r0, w0, p0, base;
    logic ext, code;
    code = (k == KIND_FETCH || k == KIND_CODE);
    ext = code ? (a > ROM_TOP_ADDR) : !(en_m && a <= SRAM_TOP_ADDR);
    base = ext ? 5 + 4 * (s + 1) : 2;
    r0 = rd_cnt;
    w0 = wr_cnt;
    p0 = psen_cnt;
    acc(k, a, d, s, rd, cyc);
    // A slow device holds wait on reads only, so writes keep the plain length
    if (slow && ext && k != KIND_XWR)
      chk_n(int'(cyc >= base + 4), 1);
    else
      chk_n(cyc, base);
    chk_n(rd_cnt - r0 + wr_cnt - w0 + psen_cnt - p0, int'(ext));
    chk_n(psen_cnt - p0, int'(ext && code));
    chk_n(wr_cnt - w0, int'(ext && k == KIND_XWR));
    if (k == KIND_XWR) begin
      if (ext)
        ext_ref[a] = d;
      else
        sram_ref[a] = d;
    end else begin
      e = a[7:0] ^ a[15:8] ^ 8'hC3;
      if (code && !ext)
        e = rom_byte(a);
      else if (!ext)
        e = sram_ref[a];
      else if (ext_ref.exists(a))
        e = ext_ref[a];
      chk(rd, e);
    end
  endtask : xacc

  task automatic wr_rd(input logic [15:0] a, input logic [7:0] d, input logic [2:0] s);
    xacc(KIND_XWR, a, d, s);
    xacc(KIND_XRD, a, 8'h00, s);
  endtask : wr_rd

  task automatic power_management_register(input logic [7:0] v);
    pm_wr <= 1'b1;
    pm_wd <= v;
    @(posedge sys_clk);
    pm_wr <= 1'b0;
    en_m = v[SRAM_EN_BIT];
    @(negedge sys_clk);
    chk(onchip_sram_enable_bit_reg, en_m);
    @(posedge sys_clk);
  endtask : power_management_register

  task automatic ptr_set(input logic idx, input logic [15:0] v);
    ptr_wr_idx <= idx;
    ptr_wr_lo <= 1'b1;
    ptr_wdata <= v[7:0];
    @(posedge sys_clk);
    ptr_wr_lo <= 1'b0;
    ptr_wr_hi <= 1'b1;
    ptr_wdata <= v[15:8];
    @(posedge sys_clk);
    ptr_wr_hi <= 1'b0;
    if (idx)
      p1m = v;
    else
      p0m = v;
  endtask : ptr_set

  // Opcode pulse; only the decrement code may move a pointer
  task automatic op(input logic s, input logic [7:0] o);
    ptr_active_sel <= s;
    opcode_valid <= 1'b1;
    opcode <= o;
    @(posedge sys_clk);
    opcode_valid <= 1'b0;
    if (o == OP_PTR_DEC && s)
      p1m--;
    else if (o == OP_PTR_DEC)
      p0m--;
    @(negedge sys_clk);
    chk(ptr0_reg, p0m);
    chk(ptr1_reg, p1m);
    @(posedge sys_clk);
  endtask : op

  // Watchdog: the tests need some 1000 cycles, this allows fifty times that
  initial begin
    #500000;
    error_cnt++;
    summarize();
  end

  initial begin
    logic [15:0] ca [4];
    logic [15:0] v;
    ca = '{16'h0000, 16'h7FFF, 16'h8000, 16'hFFFF};
    {rst_n, pm_wr, pm_wd, ptr_active_sel, ptr_wr_lo, ptr_wr_hi, ptr_wr_idx, ptr_wdata} = '0;
    {opcode_valid, opcode, wait_en, slow, en_m, p0m, p1m, rom_rdata, stretch_cfg} = '0;
    {error_cnt, cmp_count} = '0;
    req = '0;
    gpio_p0 = 8'h5A;
    gpio_p2 = 8'h3C;
    gpio_p4_0 = 1'b1;
    void'($urandom(15));
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    chk({ready_reg, onchip_sram_enable_bit_reg, bus_reg.rd_n, bus_reg.wr_n}, 16'h000B);
    @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    chk(bus_reg.p0_oe, {8'h00, ~gpio_p0});
    chk(bus_reg.p2_oe, 16'h0000);
    @(posedge sys_clk);
    $display("test reset_idle done");
    wr_rd(16'h0010, 8'h11, 3'h0);
    wr_rd(16'h03FF, 8'h22, 3'h1);
    power_management_register(8'hFE);
    power_management_register(8'h01);
    wr_rd(16'h0000, 8'h33, 3'h0);
    wr_rd(16'h03FF, 8'h44, 3'h0);
    wr_rd(16'h0400, 8'h55, 3'h0);
    power_management_register(8'h00);
    xacc(KIND_XRD, 16'h03FF, 8'h00, 3'h0);
    power_management_register(8'h01);
    $display("test routing done");
    for (int s = 0; s < 8; s++)
      xacc(KIND_XRD, 16'h1234, 8'h00, s[2:0]);
    $display("test stretch done");
    foreach (ca[i]) begin
      xacc(KIND_FETCH, ca[i], 8'h00, 3'h2);
      xacc(KIND_CODE, ca[i], 8'h00, 3'h2);
    end
    $display("test code_space done");
    ptr_set(1'b0, 16'h1200);
    ptr_set(1'b1, 16'h0000);
    op(1'b1, OP_PTR_DEC);
    op(1'b0, OP_PTR_DEC);
    op(1'b0, 8'hA4);
    repeat (4) begin
      v = 16'($urandom);
      ptr_set(v[0], v);
      op(v[0], OP_PTR_DEC);
    end
    $display("test pointers done");
    // A low general value would drive the pin, unless the wait function holds it off
    gpio_p4_0 <= 1'b0;
    wait_en <= 1'b1;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    chk(wpoe, 16'h0000);
    @(posedge sys_clk);
    slow = 1'b1;
    wr_rd(16'h2000, 8'h66, 3'h1);
    slow = 1'b0;
    wait_en <= 1'b0;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    chk({wpoe, wpo}, 16'h0002);
    @(posedge sys_clk);
    $display("test wait done");
    repeat (12) begin
      v = 16'($urandom) & 16'h07FF;
      wr_rd(v, 8'($urandom), 3'($urandom));
      xacc(KIND_FETCH, 16'($urandom), 8'h00, 3'($urandom));
    end
    $display("test random done");
    summarize();
  end
endmodule : mad_top_tb
